// *** design/serial_decode.sv ***
// Address decode, line driver control, receive echo and interrupt routing
// for a two-channel isolated serial card.
// Assumes host bus pins and line inputs are asynchronous; the UART signals
// (rts, txBusy, txData, bitTick, interrupt) share clk.
//
// Summary of operation
// - Compare A9..A3 with seven switch positions
// - Switch off needs one, on needs zero
// - A2..A0 pick register inside channel
// - Clear-to-send needed; jumper forces it active
// - Software mode: driver follows UART rts
// - Auto mode: driver follows transmit buffer
// - Receiver configurable as one-way or two-way
// - Full duplex sends and receives together
// - Half duplex two-way echoes own characters
// - Half duplex one-way blocks receiver transmitting
// - Interrupt to IRQ2-7 or 10-15, not 13
// - Auto driver held one character after transfer
`timescale 1ns/100ps
`default_nettype none

module serial_decode (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEnable,
   // Host I/O bus pins
   input wire logic [9:0] hostAddr,
   input wire logic ioReadN,
   input wire logic ioWriteN,
   // Address switches, bit 6 is A9, one means switch on
   input wire logic [6:0] channelAAddrSwitch,
   input wire logic [6:0] channelBAddrSwitch,
   // Jumpers per channel, bit 0 is channel A
   input wire logic [1:0] ctsForce,
   input wire logic [1:0] rtsSelect,
   input wire logic [1:0] autoSelect,
   input wire logic [1:0] receiverTwoWaySelect,
   input wire logic [1:0] fullDuplexSelect,
   input wire logic [3:0] channelAIrqSelect,
   input wire logic [3:0] channelBIrqSelect,
   // UART side per channel
   input wire logic [1:0] asyncCommElementRts,
   input wire logic [1:0] txBusy,
   input wire logic [1:0] txData,
   input wire logic [1:0] bitTick,
   input wire logic [1:0] uartIrq,
   // Line side pins per channel
   input wire logic [1:0] ctsIn,
   input wire logic [1:0] rxLine,
   // Decode results
   output logic [1:0] regSelect,
   output logic [2:0] regIndex,
   // Per channel line control
   output logic [1:0] ctsToUart,
   output logic [1:0] driverEnable,
   output logic [1:0] rxToUart,
   // Host interrupt lines, tri-state drive: level driven high or low while enabled
   output logic [15:0] irqLevel,
   output logic [15:0] irqEnable
);

   typedef struct packed {
      logic [9:0] addrSync1;
      logic [9:0] addrSync2;
      logic rdSync1;
      logic rdSync2;
      logic wrSync1;
      logic wrSync2;
      logic [1:0] ctsSync1;
      logic [1:0] ctsSync2;
      logic [1:0] rxSync1;
      logic [1:0] rxSync2;
      logic [1:0] regSelect;
      logic [2:0] regIndex;
      logic [1:0] ctsToUart;
      logic [1:0] driverEnable;
      logic [1:0] rxToUart;
      logic [1:0][3:0] holdCount;
      logic [15:0] irqLevel;
      logic [15:0] irqEnable;
   } state_t;

   state_t st;
   state_t next_st;
   logic [1:0][6:0] switchOn;
   logic [1:0][3:0] irqSelect;

   assign switchOn[0] = channelAAddrSwitch;
   assign switchOn[1] = channelBAddrSwitch;
   assign irqSelect[0] = channelAIrqSelect;
   assign irqSelect[1] = channelBIrqSelect;

   always_comb begin
      logic ioCycle;
      logic ctsOk;
      logic autoOn;
      ioCycle = 1'b0;
      ctsOk = 1'b0;
      autoOn = 1'b0;
      next_st = st;
      // Pin synchronisers, strobes stored active high
      next_st.addrSync1 = hostAddr;
      next_st.addrSync2 = st.addrSync1;
      next_st.rdSync1 = ~ioReadN;
      next_st.rdSync2 = st.rdSync1;
      next_st.wrSync1 = ~ioWriteN;
      next_st.wrSync2 = st.wrSync1;
      next_st.ctsSync1 = ctsIn;
      next_st.ctsSync2 = st.ctsSync1;
      next_st.rxSync1 = rxLine;
      next_st.rxSync2 = st.rxSync1;
      ioCycle = st.rdSync2 | st.wrSync2;
      next_st.regIndex =
         st.addrSync2[serial_decode_pkg::INDEX_W-1:0];
      for (int ch = 0; ch < serial_decode_pkg::CHANNELS; ch++) begin
         next_st.regSelect[ch] = ioCycle &&
            (st.addrSync2[serial_decode_pkg::SEL_MSB:
                          serial_decode_pkg::SEL_LSB] == ~switchOn[ch]);
         ctsOk = ctsForce[ch] | st.ctsSync2[ch];
         next_st.ctsToUart[ch] = ctsOk;
         if (txBusy[ch]) begin
            next_st.holdCount[ch] = serial_decode_pkg::CHAR_BITS;
         end else if (bitTick[ch] && st.holdCount[ch] != 4'h0) begin
            next_st.holdCount[ch] = st.holdCount[ch] - 4'h1;
         end
         autoOn = txBusy[ch] || st.holdCount[ch] != 4'h0;
         if (autoSelect[ch]) begin
            next_st.driverEnable[ch] = ctsOk & autoOn;
         end else if (rtsSelect[ch]) begin
            next_st.driverEnable[ch] = ctsOk & asyncCommElementRts[ch];
         end else begin
            next_st.driverEnable[ch] = 1'b0;
         end
         if (!fullDuplexSelect[ch] && st.driverEnable[ch]) begin
            next_st.rxToUart[ch] = receiverTwoWaySelect[ch] ?
               txData[ch] : serial_decode_pkg::RX_IDLE;
         end else begin
            next_st.rxToUart[ch] = st.rxSync2[ch];
         end
      end
      for (int ln = 0; ln < serial_decode_pkg::IRQ_LINES; ln++) begin
         next_st.irqLevel[ln] = 1'b0;
         next_st.irqEnable[ln] = 1'b0;
         for (int ch = 0; ch < serial_decode_pkg::CHANNELS; ch++) begin
            if (serial_decode_pkg::IRQ_VALID[ln] &&
                irqSelect[ch] == ln[3:0]) begin
               next_st.irqEnable[ln] = 1'b1;
               next_st.irqLevel[ln] = next_st.irqLevel[ln] | uartIrq[ch];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
         st.rxSync1 <= {2{serial_decode_pkg::RX_IDLE}};
         st.rxSync2 <= {2{serial_decode_pkg::RX_IDLE}};
         st.rxToUart <= {2{serial_decode_pkg::RX_IDLE}};
         st.holdCount <= {2{serial_decode_pkg::HOLD_RESET}};
      end else if (clkEnable) begin
         st <= next_st;
      end
   end

   assign regSelect = st.regSelect;
   assign regIndex = st.regIndex;
   assign ctsToUart = st.ctsToUart;
   assign driverEnable = st.driverEnable;
   assign rxToUart = st.rxToUart;
   assign irqLevel = st.irqLevel;
   assign irqEnable = st.irqEnable;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   logic sampledCycle;
   assign sampledCycle = st.rdSync2 | st.wrSync2;

   a_decode_match_a: assert property (
      clkEnable && sampledCycle &&
      st.addrSync2[9:3] == ~channelAAddrSwitch |=> regSelect[0])
      else $error("channel A not selected on matching address");

   a_switch_sense: assert property (
      $past(clkEnable) && regSelect[0] |->
      $past(st.addrSync2[9:3]) == ~$past(channelAAddrSwitch))
      else $error("channel A selected on wrong address");

   a_decode_match_b: assert property (
      clkEnable && sampledCycle &&
      st.addrSync2[9:3] == ~channelBAddrSwitch |=> regSelect[1])
      else $error("channel B not selected on matching address");

   a_index_pass: assert property (
      $past(clkEnable) && |regSelect |->
      regIndex == $past(st.addrSync2[2:0]))
      else $error("register index does not follow A2..A0");

   a_select_cycle: assert property (
      $past(clkEnable) && |regSelect |-> $past(sampledCycle))
      else $error("select outside an I/O cycle");

   a_cts_forced: assert property (
      clkEnable && ctsForce[0] |=> ctsToUart[0])
      else $error("forced clear-to-send not active");

   a_rts_follow: assert property (
      clkEnable && (ctsForce[0] || st.ctsSync2[0]) && rtsSelect[0] &&
      !autoSelect[0] |=> driverEnable[0] == $past(asyncCommElementRts[0]))
      else $error("driver does not follow rts");

   a_auto_drive: assert property (
      clkEnable && ctsForce[1] && autoSelect[1] && txBusy[1]
      ##1 clkEnable && !txBusy[1] && !bitTick[1] |=> driverEnable[1])
      else $error("auto driver dropped too early");

   a_hold_load: assert property (
      clkEnable && txBusy[1] ##1 clkEnable && !txBusy[1] && bitTick[1]
      |=> st.holdCount[1] == 4'h9)
      else $error("hold count not loaded with one character");

   a_echo_back: assert property (
      clkEnable && !fullDuplexSelect[0] && receiverTwoWaySelect[0] &&
      driverEnable[0] |=> rxToUart[0] == $past(txData[0]))
      else $error("local echo missing");

   a_echo_block: assert property (
      clkEnable && !fullDuplexSelect[0] && !receiverTwoWaySelect[0] &&
      driverEnable[0] |=> rxToUart[0])
      else $error("receiver not blocked while sending");

   a_full_pass: assert property (
      clkEnable && fullDuplexSelect[1] |=> rxToUart[1] == $past(st.rxSync2[1]))
      else $error("full duplex receive not passed");

   // Driver gating and hold counter
   a_cts_gate: assert property (
      clkEnable && !ctsForce[0] && !st.ctsSync2[0] |=> !driverEnable[0])
      else $error("driver enabled without clear-to-send");

   a_no_source: assert property (
      clkEnable && !autoSelect[1] && !rtsSelect[1] |=> !driverEnable[1])
      else $error("driver enabled with no control source");

   a_hold_count: assert property (
      clkEnable && !txBusy[1] && bitTick[1] && st.holdCount[1] != 4'h0
      |=> st.holdCount[1] == $past(st.holdCount[1]) - 4'h1)
      else $error("hold count did not step down on a bit tick");

   // Both selections invalid: every line released
   a_irq_release: assert property (
      clkEnable && !serial_decode_pkg::IRQ_VALID[channelAIrqSelect] &&
      !serial_decode_pkg::IRQ_VALID[channelBIrqSelect]
      |=> irqEnable == 16'h0000)
      else $error("interrupt line driven with no valid selection");

   a_irq_valid: assert property (
      (irqEnable & ~serial_decode_pkg::IRQ_VALID) == 16'h0000)
      else $error("invalid interrupt line driven");

   a_irq_only: assert property (
      clkEnable && channelAIrqSelect == 4'h5 && channelBIrqSelect == 4'h5
      |=> irqEnable == 16'h0020 && irqLevel[5] == $past(|uartIrq))
      else $error("interrupt routing drives wrong lines");

   c_select_a: cover property (regSelect[0] && regIndex == 3'h5);
   c_auto_hold: cover property (driverEnable[0] && !txBusy[0]);
   c_echo: cover property (driverEnable[1] && !fullDuplexSelect[1] &&
      receiverTwoWaySelect[1]);
   c_irq_high: cover property (irqEnable[15] && irqLevel[15]);
   c_hold_end: cover property (driverEnable[1] && bitTick[1] &&
      st.holdCount[1] == 4'h1);

endmodule : serial_decode

`default_nettype wire

// *** design/serial_decode_pkg.sv ***
// Constants for the two-channel serial adapter decode and driver control.
// Assumes one 25 MHz clock and a ten-bit host I/O address.
package serial_decode_pkg;
   localparam int ADDR_W = 10;
   localparam int SEL_MSB = 9;
   localparam int SEL_LSB = 3;
   localparam int SEL_W = 7;
   localparam int INDEX_W = 3;
   localparam int CHANNELS = 2;
   localparam int IRQ_LINES = 16;
   localparam int IRQ_SEL_W = 4;
   // Lines a channel may claim: 2 to 7, 10 to 15 except 13
   localparam logic [15:0] IRQ_VALID = 16'hdcfc;
   // Driver hold after the last character, in bit periods
   localparam logic [3:0] CHAR_BITS = 4'ha;
   localparam logic [3:0] HOLD_RESET = 4'h0;
   localparam logic RX_IDLE = 1'h1;
endpackage : serial_decode_pkg

// *** tb/host_model.sv ***
// Host processor model: drives I/O read and write cycles on the card.
// Assumes the bench calls its tasks from a process synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module host_model (
   // Clock
   input wire logic clk,
   // Host I/O bus
   output logic [9:0] hostAddr,
   output logic ioReadN,
   output logic ioWriteN
);
   initial begin
      hostAddr = 10'h3ff;
      ioReadN = 1'h1;
      ioWriteN = 1'h1;
   end

   // Address and strobe held together until stop is called
   task start(input logic [9:0] addr, input logic wr);
      @(posedge clk);
      hostAddr <= addr;
      ioReadN <= wr;
      ioWriteN <= !wr;
   endtask : start

   // Released bus shows the inverse of the last address
   task stop();
      @(posedge clk);
      ioReadN <= 1'h1;
      ioWriteN <= 1'h1;
      hostAddr <= ~hostAddr;
   endtask : stop
endmodule : host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the serial card decode and line control.
// Assumes the host model drives the bus; the bench plays UART and jumpers.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic clkEnable = 1'h1;
   logic [9:0] hostAddr;
   logic ioReadN, ioWriteN;
   // Channel A at 2d8, channel B at 2e8; one means switch on
   logic [6:0] channelAAddrSwitch = 7'h24;
   logic [6:0] channelBAddrSwitch = 7'h22;
   logic [1:0] ctsForce = 2'h3, rtsSelect = 2'h0, autoSelect = 2'h0;
   logic [1:0] receiverTwoWaySelect = 2'h0, fullDuplexSelect = 2'h0;
   logic [3:0] channelAIrqSelect = 4'h0, channelBIrqSelect = 4'h0;
   logic [1:0] asyncCommElementRts = 2'h0, txBusy = 2'h0, txData = 2'h3;
   logic [1:0] bitTick = 2'h0, uartIrq = 2'h0, ctsIn = 2'h0, rxLine = 2'h3;
   logic [1:0] regSelect, ctsToUart, driverEnable, rxToUart;
   logic [2:0] regIndex;
   logic [15:0] irqLevel, irqEnable;
   int failCount = 0, totalChecks = 0, cycles = 0;

   serial_decode DUT (
      .clk(clk),
      .reset(reset),
      .clkEnable(clkEnable),
      .hostAddr(hostAddr),
      .ioReadN(ioReadN),
      .ioWriteN(ioWriteN),
      .channelAAddrSwitch(channelAAddrSwitch),
      .channelBAddrSwitch(channelBAddrSwitch),
      .ctsForce(ctsForce),
      .rtsSelect(rtsSelect),
      .autoSelect(autoSelect),
      .receiverTwoWaySelect(receiverTwoWaySelect),
      .fullDuplexSelect(fullDuplexSelect),
      .channelAIrqSelect(channelAIrqSelect),
      .channelBIrqSelect(channelBIrqSelect),
      .asyncCommElementRts(asyncCommElementRts),
      .txBusy(txBusy),
      .txData(txData),
      .bitTick(bitTick),
      .uartIrq(uartIrq),
      .ctsIn(ctsIn),
      .rxLine(rxLine),
      .regSelect(regSelect),
      .regIndex(regIndex),
      .ctsToUart(ctsToUart),
      .driverEnable(driverEnable),
      .rxToUart(rxToUart),
      .irqLevel(irqLevel),
      .irqEnable(irqEnable)
   );
   host_model host (
      .clk(clk),
      .hostAddr(hostAddr),
      .ioReadN(ioReadN),
      .ioWriteN(ioWriteN)
   );

   always #20 clk = ~clk;

   task printVerdict();
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : printVerdict

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failCount++;
         printVerdict();
      end
   end

   task w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : w

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task testDecode();
      host.start(10'h2dd, 1'h0);
      w(4);
      chk("select read", 16'h1, regSelect);
      chk("index read", 16'h5, regIndex);
      host.stop();
      w(4);
      chk("select idle", 16'h0, regSelect);
      host.start(10'h2eb, 1'h1);
      w(4);
      chk("select write", 16'h2, regSelect);
      chk("index write", 16'h3, regIndex);
      host.start(10'h2f8, 1'h0);
      w(4);
      chk("select miss", 16'h0, regSelect);
      host.stop();
      $display("decode test done");
   endtask : testDecode

   task testDriver();
      @(posedge clk);
      // one driver source on channel A
      rtsSelect <= 2'h1;
      ctsForce <= 2'h2;
      asyncCommElementRts <= 2'h1;
      w(3);
      chk("driver without cts", 16'h0, driverEnable);
      @(posedge clk);
      ctsIn <= 2'h1;
      w(4);
      chk("driver rts on", 16'h1, driverEnable);
      @(posedge clk);
      asyncCommElementRts <= 2'h0;
      autoSelect <= 2'h2;
      txBusy <= 2'h2;
      w(2);
      chk("driver auto on", 16'h2, driverEnable);
      @(posedge clk);
      txBusy <= 2'h0;
      for (int i = 1; i <= serial_decode_pkg::CHAR_BITS; i++) begin
         @(posedge clk);
         bitTick <= 2'h2;
         @(posedge clk);
         bitTick <= 2'h0;
         #1;
         if (i == serial_decode_pkg::CHAR_BITS - 1)
            chk("driver hold", 16'h2, driverEnable);
      end
      w(2);
      chk("driver hold end", 16'h0, driverEnable);
      $display("driver test done");
   endtask : testDriver

   task testEcho();
      // half duplex for the shared pair
      @(posedge clk);
      asyncCommElementRts <= 2'h1;
      txData <= 2'h2;
      receiverTwoWaySelect <= 2'h1;
      w(3);
      chk("local echo", 16'h2, rxToUart);
      @(posedge clk);
      receiverTwoWaySelect <= 2'h0;
      w(2);
      chk("echo blocked", 16'h3, rxToUart);
      @(posedge clk);
      fullDuplexSelect <= 2'h3;
      rxLine <= 2'h2;
      w(4);
      chk("full duplex rx", 16'h2, rxToUart);
      $display("echo test done");
   endtask : testEcho

   task testIrq();
      logic [15:0] exp;
      @(posedge clk);
      uartIrq <= 2'h1;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         channelAIrqSelect <= 4'(i);
         w(3);
         exp = serial_decode_pkg::IRQ_VALID[i] ? 16'h1 << i : 16'h0;
         chk("irq enable", exp, irqEnable);
         chk("irq level", exp, irqLevel);
      end
      @(posedge clk);
      channelAIrqSelect <= 4'h5;
      channelBIrqSelect <= 4'h5;
      w(3);
      chk("irq shared enable", 16'h0020, irqEnable);
      chk("irq shared level", 16'h0020, irqLevel);
      @(posedge clk);
      clkEnable <= 1'h0;
      channelAIrqSelect <= 4'h3;
      channelBIrqSelect <= 4'h3;
      w(3);
      chk("irq frozen", 16'h0020, irqEnable);
      @(posedge clk);
      clkEnable <= 1'h1;
      w(2);
      chk("irq thawed", 16'h0008, irqEnable);
      $display("interrupt test done");
   endtask : testIrq

   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'h0;
      w(2);
      testDecode();
      testDriver();
      testEcho();
      testIrq();
      printVerdict();
   end
endmodule : tb_top
`default_nettype wire
